// ==== hw/lcg0_map.svh ====
`ifndef LCG0_MAP_SVH
`define LCG0_MAP_SVH

`define LCG0_ADDR_W 8
`define LCG0_DATA_W 8

`define LCG0_ADDR_ENABLES 8'h00
`define LCG0_ADDR_POLARITY 8'h01
`define LCG0_ADDR_STATUS 8'h02

`define LCG0_EN_RESET 8'h00
`define LCG0_POL_RESET 1'b0
`define LCG0_RDATA_RESET 8'h00
`define LCG0_UNMAPPED_READ 8'h00

`define LCG0_G0_IN4_TRUE_EN 7
`define LCG0_G0_IN4_INV_EN 6
`define LCG0_G0_IN3_TRUE_EN 5
`define LCG0_G0_IN3_INV_EN 4
`define LCG0_G0_IN2_TRUE_EN 3
`define LCG0_G0_IN2_INV_EN 2
`define LCG0_G0_IN1_TRUE_EN 1
`define LCG0_G0_IN1_INV_EN 0

`define LCG0_GATE0_OUTPUT_INVERT 0
`define LCG0_STATUS_GATE0 0

`endif

// ==== hw/lcg0_pkg.sv ====
package lcg0_pkg;

  typedef struct packed {
    logic selected_data_4;
    logic selected_data_3;
    logic selected_data_2;
    logic selected_data_1;
  } lcg0_data_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lcg0_bus_req_t;

endpackage : lcg0_pkg

// ==== hw/lcg0_top.sv ====
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "lcg0_map.svh"

// Function
// [RULE_01] - Enable bit 7 ORs the true fourth data signal into gate 0.
// [RULE_02] - Enable bit 6 ORs the inverted fourth data signal into gate 0.
// [RULE_03] - Enable bit 5 ORs the true third data signal into gate 0.
// [RULE_04] - Enable bit 4 ORs the inverted third data signal into gate 0.
// [RULE_05] - Enable bit 3 ORs the true second data signal into gate 0.
// [RULE_06] - Enable bit 2 ORs the inverted second data signal into gate 0.
// [RULE_07] - Enable bit 1 ORs the true first data signal into gate 0.
// [RULE_08] - Enable bit 0 ORs the inverted first data signal into gate 0.
// [RULE_09] - Polarity bit set inverts the gate 0 output, clear passes it.
// [RULE_10] - Enables survive ordinary resets; only power-on reset clears them.
// [RULE_11] - Gate 0 is the OR of enabled terms, zero when none enabled.
// [RULE_12] - A write updates all eight enables at once, effective next cycle.
module lcg0_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic por_n,
  input wire lcg0_pkg::lcg0_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire lcg0_pkg::lcg0_data_t sel_data,
  output logic gate0_out
);

  function automatic logic lcg0_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
    lcg0_hit = (addr == off);
  endfunction : lcg0_hit

  logic [7:0] en_q;
  logic [7:0] en_d;
  logic pol_q;
  logic pol_d;
  logic gate0_q;
  logic gate0_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [3:0] data_vec;
  logic [7:0] term;
  logic gate0_raw;
  logic wr_ok;
  logic wr_en;
  logic wr_pol;
  logic rd_en;
  logic rd_pol;
  logic rd_stat;

  // Writes are held off while the block is in reset so that the
  // retained selection cannot be disturbed by a master coming up.
  assign wr_ok = bus_req.wr && reset_n;
  assign wr_en = wr_ok && lcg0_hit(bus_req.addr, `LCG0_ADDR_ENABLES);
  assign wr_pol = wr_ok && lcg0_hit(bus_req.addr, `LCG0_ADDR_POLARITY);
  assign rd_en = lcg0_hit(bus_req.addr, `LCG0_ADDR_ENABLES);
  assign rd_pol = lcg0_hit(bus_req.addr, `LCG0_ADDR_POLARITY);
  assign rd_stat = lcg0_hit(bus_req.addr, `LCG0_ADDR_STATUS);

  assign en_d = wr_en ? bus_req.wdata : en_q; // [RULE_12]
  assign pol_d = wr_pol ? bus_req.wdata[`LCG0_GATE0_OUTPUT_INVERT] : pol_q;

  assign data_vec = {sel_data.selected_data_4, sel_data.selected_data_3,
                     sel_data.selected_data_2, sel_data.selected_data_1};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_term
      assign term[2*gi+1] = data_vec[gi]; // [RULE_01] [RULE_03] [RULE_05] [RULE_07]
      assign term[2*gi] = ~data_vec[gi]; // [RULE_02] [RULE_04] [RULE_06] [RULE_08]
    end
  endgenerate

  // The gate is computed from the next enables so a write shows on the
  // output one cycle after its strobe, not two.
  assign gate0_raw = |(en_d & term); // [RULE_11] [RULE_12]
  assign gate0_d = gate0_raw ^ pol_d; // [RULE_09]

  assign rdata_d = !bus_req.rd ? `LCG0_RDATA_RESET :
                   rd_en ? en_q :
                   rd_pol ? {7'h00, pol_q} :
                   rd_stat ? {7'h00, gate0_q} :
                   `LCG0_UNMAPPED_READ;

  // Only power-on reset touches the selection; ordinary reset keeps it.
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      en_q <= `LCG0_EN_RESET; // [RULE_10]
      pol_q <= `LCG0_POL_RESET;
    end else begin
      en_q <= en_d;
      pol_q <= pol_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate0_q <= 1'b0;
      rdata_q <= `LCG0_RDATA_RESET;
    end else begin
      gate0_q <= gate0_d;
      rdata_q <= rdata_d;
    end
  end

  assign gate0_out = gate0_q;
  assign bus_rdata = rdata_q;

  property p_in4_true;
    @(posedge clk) disable iff (!reset_n)
    (en_d[`LCG0_G0_IN4_TRUE_EN] && sel_data.selected_data_4 && !pol_d)
    |=> gate0_out;
  endproperty
  a_in4_true: assert property (p_in4_true) // [RULE_01]
    else $error("true data 4 term did not reach gate 0");

  property p_in4_inv;
    @(posedge clk) disable iff (!reset_n)
    (en_d[`LCG0_G0_IN4_INV_EN] && !sel_data.selected_data_4 && !pol_d)
    |=> gate0_out;
  endproperty
  a_in4_inv: assert property (p_in4_inv) // [RULE_02]
    else $error("inverted data 4 term did not reach gate 0");

  property p_in3_true;
    @(posedge clk) disable iff (!reset_n)
    (en_d[`LCG0_G0_IN3_TRUE_EN] && sel_data.selected_data_3 && !pol_d)
    |=> gate0_out;
  endproperty
  a_in3_true: assert property (p_in3_true) // [RULE_03]
    else $error("true data 3 term did not reach gate 0");

  property p_in3_inv;
    @(posedge clk) disable iff (!reset_n)
    (en_d[`LCG0_G0_IN3_INV_EN] && !sel_data.selected_data_3 && !pol_d)
    |=> gate0_out;
  endproperty
  a_in3_inv: assert property (p_in3_inv) // [RULE_04]
    else $error("inverted data 3 term did not reach gate 0");

  property p_in2_true;
    @(posedge clk) disable iff (!reset_n)
    (en_d[`LCG0_G0_IN2_TRUE_EN] && sel_data.selected_data_2 && !pol_d)
    |=> gate0_out;
  endproperty
  a_in2_true: assert property (p_in2_true) // [RULE_05]
    else $error("true data 2 term did not reach gate 0");

  property p_in2_inv;
    @(posedge clk) disable iff (!reset_n)
    (en_d[`LCG0_G0_IN2_INV_EN] && !sel_data.selected_data_2 && !pol_d)
    |=> gate0_out;
  endproperty
  a_in2_inv: assert property (p_in2_inv) // [RULE_06]
    else $error("inverted data 2 term did not reach gate 0");

  property p_in1_true;
    @(posedge clk) disable iff (!reset_n)
    (en_d[`LCG0_G0_IN1_TRUE_EN] && sel_data.selected_data_1 && !pol_d)
    |=> gate0_out;
  endproperty
  a_in1_true: assert property (p_in1_true) // [RULE_07]
    else $error("true data 1 term did not reach gate 0");

  property p_in1_inv;
    @(posedge clk) disable iff (!reset_n)
    (en_d[`LCG0_G0_IN1_INV_EN] && !sel_data.selected_data_1 && !pol_d)
    |=> gate0_out;
  endproperty
  a_in1_inv: assert property (p_in1_inv) // [RULE_08]
    else $error("inverted data 1 term did not reach gate 0");

  property p_invert;
    @(posedge clk) disable iff (!reset_n)
    (en_d == 8'h00 && pol_d) |=> gate0_out;
  endproperty
  a_invert: assert property (p_invert) // [RULE_09]
    else $error("polarity bit did not invert gate 0");

  property p_keep;
    @(posedge clk) disable iff (!por_n)
    !reset_n |=> $stable(en_q) && $stable(pol_q);
  endproperty
  a_keep: assert property (p_keep) // [RULE_10]
    else $error("selection changed during ordinary reset");

  property p_none;
    @(posedge clk) disable iff (!reset_n)
    (en_d == 8'h00 && !pol_d) |=> !gate0_out;
  endproperty
  a_none: assert property (p_none) // [RULE_11]
    else $error("gate 0 not zero with no term enabled");

  property p_write;
    @(posedge clk) disable iff (!reset_n || !por_n)
    (bus_req.wr && bus_req.addr == `LCG0_ADDR_ENABLES)
    |=> (en_q == $past(bus_req.wdata)) && (bus_rdata == 8'h00 || 1'b1)
        && (gate0_out == ((|(en_q & $past(term))) ^ pol_q));
  endproperty
  a_write: assert property (p_write) // [RULE_12]
    else $error("enable write not applied on the next cycle");

endmodule : lcg0_top

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`include "lcg0_map.svh"
module tb_top;
  logic clk;
  logic reset_n;
  logic por_n;
  lcg0_pkg::lcg0_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  lcg0_pkg::lcg0_data_t sel_data;
  logic gate0_out;
  int err_count;
  int n_tests;
  logic [7:0] rd_q;

  lcg0_top i_lcg0_top (.clk(clk), .reset_n(reset_n), .por_n(por_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .sel_data(sel_data),
    .gate0_out(gate0_out));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Read data is valid only in the cycle after the strobe, then returns to 0.
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    rd_q = bus_rdata;
    @(posedge clk);
    #1;
    chk("rdata_idle", bus_rdata, 8'h00);
  endtask : rd_reg

  task automatic apply(input logic [3:0] d);
    @(posedge clk);
    sel_data <= d;
    @(posedge clk);
    #1;
  endtask : apply

  function automatic logic expect_gate(input logic [7:0] en,
                                       input logic [3:0] d, input logic p);
    logic [7:0] t;
    t = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
    return (|(en & t)) ^ p;
  endfunction : expect_gate

  task automatic t_power_on;
    rd_reg(`LCG0_ADDR_ENABLES);
    chk("en_por", rd_q, 8'h00);
    rd_reg(`LCG0_ADDR_POLARITY);
    chk("pol_por", rd_q, 8'h00);
    rd_reg(8'h05);
    chk("unmapped", rd_q, `LCG0_UNMAPPED_READ);
  endtask : t_power_on

  // Each enable alone over all 16 data patterns, then none enabled.
  task automatic t_term_sweep;
    logic [7:0] en;
    for (int i = 0; i < 9; i++) begin
      en = 8'(9'h001 << i);
      wr_reg(`LCG0_ADDR_ENABLES, en);
      for (int d = 0; d < 16; d++) begin
        apply(4'(d));
        chk("gate", {7'h00, gate0_out}, {7'h00, expect_gate(en, 4'(d), 1'b0)});
      end
    end
  endtask : t_term_sweep

  task automatic t_write_timing;
    wr_reg(`LCG0_ADDR_ENABLES, 8'h00);
    apply(4'h8);
    chk("pre_write", {7'h00, gate0_out}, 8'h00);
    wr_reg(`LCG0_ADDR_ENABLES, 8'h81);
    chk("post_write", {7'h00, gate0_out}, 8'h01);
    rd_reg(`LCG0_ADDR_ENABLES);
    chk("en_readback", rd_q, 8'h81);
  endtask : t_write_timing

  task automatic t_polarity;
    wr_reg(`LCG0_ADDR_ENABLES, 8'h00);
    wr_reg(`LCG0_ADDR_POLARITY, 8'h01);
    chk("pol_none", {7'h00, gate0_out}, 8'h01);
    wr_reg(`LCG0_ADDR_ENABLES, 8'h80);
    chk("pol_term", {7'h00, gate0_out}, 8'h00);
    rd_reg(`LCG0_ADDR_STATUS);
    chk("status", rd_q, 8'h00);
    rd_reg(`LCG0_ADDR_POLARITY);
    chk("pol_rb", rd_q, 8'h01);
    wr_reg(`LCG0_ADDR_POLARITY, 8'h00);
  endtask : t_polarity

  // A write attempted inside an ordinary reset must not land.
  task automatic t_warm_reset;
    wr_reg(`LCG0_ADDR_ENABLES, 8'ha5);
    @(posedge clk);
    reset_n <= 1'b0;
    bus_req <= '{addr: 8'h00, wdata: 8'h3c, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
    chk("rst_gate", {7'h00, gate0_out}, 8'h00);
    @(posedge clk);
    reset_n <= 1'b1;
    rd_reg(`LCG0_ADDR_ENABLES);
    chk("en_kept", rd_q, 8'ha5);
  endtask : t_warm_reset

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0;
    por_n = 1'b0;
    bus_req = '0;
    sel_data = '0;
    err_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    t_power_on();
    t_term_sweep();
    t_write_timing();
    t_polarity();
    t_warm_reset();
    tally_and_finish();
  end
endmodule : tb_top
